// [aib_defines.svh]
// Constants for the auxiliary interrupt and breakpoint block
// Functional notes
// (RL1) All auxiliary requests leave through one shared vector address 0033h.
// (RL2) Pending-index reads a 4-bit source code, upper nibble zero.
// (RL3) Auxiliary bit 0 is highest priority, bit 7 lowest.
// (RL4) Enable register write stores one mask bit per source, 1 enables.
// (RL5) Enable register reads raw requests when select is 0, masks when 1.
// (RL6) Poll register bit 0 write sets select; reads the opposite view.
// (RL7) Status bit is one only when its source is active and enabled.
// (RL8) Reading summation low byte clears the summation request.
// (RL9) Reading conversion low byte clears it; active request blocks new results.
// (RL10) Extended control bit 4 gates the whole auxiliary group.
// (RL11) Global gate bit 7 blocks classic sources, never auxiliary ones.
// (RL12) Classic enable bits 6..0 mask serial1, timer2, serial0, timer1, ext1, timer0, ext0.
// (RL13) Any breakpoint control write arms the selected unit with current address bytes.
// (RL14) Control bit 7 reads any match; writing 1 clears selected match.
// (RL15) Space select bit 1: 0 data memory, 1 program memory.
// (RL16) Enable bit 0 lets the selected breakpoint unit match.
// (RL17) Breakpoint address is 16 bits, low and high byte registers.
// (RL18) Breakpoint match and digital low voltage share auxiliary bit 0.
// (RL19) SPI receive and two-wire status share auxiliary bit 2.
// (RL20) Pending index reports the highest enabled active request, else zero.
// (RL21) All registers of this block clear to zero on reset.
`ifndef AIB_DEFINES_SVH
`define AIB_DEFINES_SVH
`define AIB_ADDR_POLL 8'hA4
`define AIB_ADDR_PEND 8'hA5
`define AIB_ADDR_AUX_EN 8'hA6
`define AIB_ADDR_AUX_STAT 8'hA7
`define AIB_ADDR_IE 8'hA8
`define AIB_ADDR_BREAKPOINT_CONTROL 8'hA9
`define AIB_ADDR_BPL 8'hAA
`define AIB_ADDR_BPH 8'hAB
`define AIB_AUX_VECTOR 16'h0033
`define AIB_RESET_BYTE 8'h00
`define AIB_BIT_VIEW_SEL 0
`define AIB_BIT_GLOBAL 7
`define AIB_BIT_BP_STAT 7
`define AIB_BIT_BP_SPACE 1
`define AIB_BIT_BP_EN 0
`define AIB_BIT_EXT_AUX 4
`define AIB_BIT_SUM 6
`define AIB_BIT_CONV 5
`endif

// [aib_pkg.sv]
// Types for the auxiliary interrupt and breakpoint block
package aib_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } aib_sfr_req_t;
    typedef struct packed {
        logic seconds;
        logic millisecond;
        logic spi_tx;
        logic spi_rx_or_twi;
        logic analog_lowv;
        logic digital_lowv;
    } aib_aux_level_t;
    typedef struct packed {
        logic [15:0] addr;
        logic valid;
    } aib_mem_access_t;
endpackage

// [aib_irq_break_ctrl.sv]
// Auxiliary interrupt gating, classic enable register and breakpoint units
`include "aib_defines.svh"
module aib_irq_break_ctrl #(
    parameter int NUM_BP = 2,
    parameter int SEL_W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire aib_pkg::aib_sfr_req_t sfr_req,
    output logic [7:0] sfr_rdata,
    input wire aib_pkg::aib_aux_level_t aux_level,
    input wire logic sum_done,
    input wire logic sum_lsb_read,
    input wire logic conv_done,
    input wire logic conv_lsb_read,
    output logic conv_result_hold,
    input wire logic [7:0] extended_irq_control,
    output logic aux_irq,
    output logic [15:0] aux_vector_addr,
    input wire logic [6:0] classic_req,
    output logic [6:0] classic_irq,
    input wire logic [SEL_W-1:0] memory_control_select,
    input wire aib_pkg::aib_mem_access_t data_access,
    input wire aib_pkg::aib_mem_access_t prog_fetch
);
    import aib_pkg::*;

    function automatic logic [3:0] aib_prio(input logic [7:0] act);
        logic [3:0] code;
        code = 4'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (act[i])
            begin
                code = 4'(i + 1);
            end
        end
        return code;
    endfunction

    logic [7:0] aux_mask;
    logic view_sel;
    logic [7:0] interrupt_enable;
    logic summation_irq_flag;
    logic conversion_irq_flag;
    logic [7:0] breakpoint_addr_low;
    logic [7:0] breakpoint_addr_high;
    logic [15:0] bp_addr [NUM_BP];
    logic [NUM_BP-1:0] bp_space;
    logic [NUM_BP-1:0] bp_en;
    logic [NUM_BP-1:0] bp_match;
    logic [NUM_BP-1:0] bp_hit;

    wire logic hit_poll = sfr_req.addr == `AIB_ADDR_POLL;
    wire logic hit_pend = sfr_req.addr == `AIB_ADDR_PEND;
    wire logic hit_en = sfr_req.addr == `AIB_ADDR_AUX_EN;
    wire logic hit_stat = sfr_req.addr == `AIB_ADDR_AUX_STAT;
    wire logic hit_ie = sfr_req.addr == `AIB_ADDR_IE;
    wire logic hit_breakpoint_control = sfr_req.addr == `AIB_ADDR_BREAKPOINT_CONTROL;
    wire logic hit_bpl = sfr_req.addr == `AIB_ADDR_BPL;
    wire logic hit_bph = sfr_req.addr == `AIB_ADDR_BPH;
    wire logic wr_breakpoint_control = sfr_req.wr && hit_breakpoint_control;
    wire logic [15:0] bp_cur_addr = {breakpoint_addr_high, breakpoint_addr_low}; // RL17
    wire logic any_bp_match = |bp_match; // RL14

    // Raw request lines in enable-register bit order
    wire logic [7:0] aux_raw = {
        aux_level.seconds,
        summation_irq_flag,
        conversion_irq_flag,
        aux_level.millisecond,
        aux_level.spi_tx,
        aux_level.spi_rx_or_twi, // RL19
        aux_level.analog_lowv,
        aux_level.digital_lowv || any_bp_match // RL18
    };
    wire logic [7:0] aux_irq_status = aux_raw & aux_mask; // RL7
    wire logic [3:0] aux_pending_index = aib_prio(aux_irq_status); // RL2 RL3 RL20
    wire logic [7:0] aux_en_view = view_sel ? aux_mask : aux_raw; // RL5
    wire logic [7:0] aux_poll_view = view_sel ? aux_raw : aux_mask; // RL6
    wire logic [7:0] breakpoint_control_view = {any_bp_match, 5'b0_0000,
        bp_space[memory_control_select], bp_en[memory_control_select]};

    wire logic [7:0] next_rdata =
        hit_poll ? aux_poll_view :
        hit_pend ? {4'h0, aux_pending_index} :
        hit_en ? aux_en_view :
        hit_stat ? aux_irq_status :
        hit_ie ? interrupt_enable :
        hit_breakpoint_control ? breakpoint_control_view :
        hit_bpl ? breakpoint_addr_low :
        hit_bph ? breakpoint_addr_high : `AIB_RESET_BYTE;

    assign aux_irq = (|aux_irq_status) && extended_irq_control[`AIB_BIT_EXT_AUX]; // RL10
    assign aux_vector_addr = `AIB_AUX_VECTOR; // RL1
    assign classic_irq = interrupt_enable[`AIB_BIT_GLOBAL] ?
        (classic_req & interrupt_enable[6:0]) : 7'h00; // RL11 RL12
    assign conv_result_hold = conversion_irq_flag; // RL9

    // Read data is latched so the core samples a stable value next cycle
    always_ff @(posedge clk)
    begin
        if (rst)
            sfr_rdata <= `AIB_RESET_BYTE;
        else if (sfr_req.rd)
            sfr_rdata <= next_rdata;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            aux_mask <= `AIB_RESET_BYTE; // RL21
            view_sel <= 1'b0;
            interrupt_enable <= `AIB_RESET_BYTE;
            breakpoint_addr_low <= `AIB_RESET_BYTE;
            breakpoint_addr_high <= `AIB_RESET_BYTE;
        end
        else if (sfr_req.wr)
        begin
            if (hit_en)
                aux_mask <= sfr_req.wdata; // RL4
            if (hit_poll)
                view_sel <= sfr_req.wdata[`AIB_BIT_VIEW_SEL]; // RL6
            if (hit_ie)
                interrupt_enable <= sfr_req.wdata; // RL12
            if (hit_bpl)
                breakpoint_addr_low <= sfr_req.wdata;
            if (hit_bph)
                breakpoint_addr_high <= sfr_req.wdata;
        end
    end

    // A completion in the same cycle as the low-byte read keeps the flag set
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            summation_irq_flag <= 1'b0;
            conversion_irq_flag <= 1'b0;
        end
        else
        begin
            summation_irq_flag <= sum_done || (summation_irq_flag && !sum_lsb_read); // RL8
            conversion_irq_flag <= conv_done || (conversion_irq_flag && !conv_lsb_read); // RL9
        end
    end

    // Per-unit compare against the chosen memory space
    for (genvar b = 0; b < NUM_BP; b++)
    begin : g_bp
        wire aib_mem_access_t acc = bp_space[b] ? prog_fetch : data_access; // RL15
        wire logic sel = memory_control_select == SEL_W'(b);
        assign bp_hit[b] = bp_en[b] && acc.valid && acc.addr == bp_addr[b]; // RL16

        always_ff @(posedge clk)
        begin
            if (rst)
            begin
                bp_addr[b] <= 16'h0000;
                bp_space[b] <= 1'b0;
                bp_en[b] <= 1'b0;
                bp_match[b] <= 1'b0;
            end
            else
            begin
                if (wr_breakpoint_control && sel)
                begin
                    bp_addr[b] <= bp_cur_addr; // RL13
                    bp_space[b] <= sfr_req.wdata[`AIB_BIT_BP_SPACE];
                    bp_en[b] <= sfr_req.wdata[`AIB_BIT_BP_EN];
                end
                // A new hit wins over a clear in the same cycle
                if (bp_hit[b])
                    bp_match[b] <= 1'b1;
                else if (wr_breakpoint_control && sel && sfr_req.wdata[`AIB_BIT_BP_STAT])
                    bp_match[b] <= 1'b0; // RL14
            end
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    pend_none_a: assert property (aux_irq_status == 8'h00 |-> aux_pending_index == 4'h0) // RL20
        else $error("pending index not zero with no enabled request");
    pend_top_a: assert property (aux_irq_status[0] |-> aux_pending_index == 4'h1) // RL3
        else $error("highest priority source not reported");
    pend_low_a: assert property (aux_irq_status == 8'h80 |-> aux_pending_index == 4'h8) // RL2
        else $error("seconds source code wrong");
    status_gate_a: assert property (sfr_req.rd && hit_stat // RL7
        |=> sfr_rdata == ($past(aux_raw) & $past(aux_mask)))
        else $error("status read not raw and mask");
    enable_view_a: assert property (sfr_req.rd && hit_en && !view_sel
        |=> sfr_rdata == $past(aux_raw)) // RL5
        else $error("enable register read wrong view");
    poll_view_a: assert property (sfr_req.rd && hit_poll && !view_sel
        |=> sfr_rdata == $past(aux_mask)) // RL6
        else $error("poll register read wrong view");
    sum_clear_a: assert property (summation_irq_flag && sum_lsb_read && !sum_done
        |=> !summation_irq_flag) // RL8
        else $error("summation request not cleared");
    conv_hold_a: assert property (conv_result_hold && !conv_lsb_read // RL9
        |=> conv_result_hold)
        else $error("conversion hold dropped early");
    aux_gate_a: assert property (!extended_irq_control[`AIB_BIT_EXT_AUX] |-> !aux_irq) // RL10
        else $error("auxiliary request passed closed gate");
    global_gate_a: assert property (!interrupt_enable[`AIB_BIT_GLOBAL] |-> classic_irq == 7'h00) // RL11
        else $error("classic request passed global gate");
    bp_status_a: assert property (sfr_req.rd && hit_breakpoint_control
        |=> sfr_rdata[`AIB_BIT_BP_STAT] == $past(any_bp_match)) // RL14
        else $error("breakpoint status read wrong");
    bp_arm_a: assert property (wr_breakpoint_control |=> bp_addr[$past(memory_control_select)]
        == $past(bp_cur_addr)) // RL13
        else $error("breakpoint not armed with current address");
    bp_share_a: assert property (any_bp_match && aux_mask[0] // RL18
        |-> aux_irq_status[0] && aux_pending_index == 4'h1)
        else $error("breakpoint match not on auxiliary bit 0");

    pend_upper_a: assert property (sfr_req.rd && hit_pend // RL2
        |=> sfr_rdata == {4'h0, $past(aux_pending_index)})
        else $error("pending index read wrong");
    pend_mid_a: assert property (aux_irq_status[5] && aux_irq_status[4:0] == 5'h00 // RL3
        |-> aux_pending_index == 4'h6)
        else $error("conversion source code wrong");
    spi_share_a: assert property (aux_level.spi_rx_or_twi && aux_mask[2] // RL19
        && aux_irq_status[1:0] == 2'b00 |-> aux_pending_index == 4'h3)
        else $error("shared receive source code wrong");
    mask_write_a: assert property (sfr_req.wr && hit_en // RL4
        |=> aux_mask == $past(sfr_req.wdata))
        else $error("enable mask not stored");
    en_mask_view_a: assert property (sfr_req.rd && hit_en && view_sel // RL5
        |=> sfr_rdata == $past(aux_mask))
        else $error("enable register read wrong mask view");
    poll_raw_view_a: assert property (sfr_req.rd && hit_poll && view_sel // RL6
        |=> sfr_rdata == $past(aux_raw))
        else $error("poll register read wrong raw view");
    view_write_a: assert property (sfr_req.wr && hit_poll // RL6
        |=> view_sel == $past(sfr_req.wdata[`AIB_BIT_VIEW_SEL]))
        else $error("read view select not stored");
    sum_set_a: assert property (sum_done // RL8
        |=> summation_irq_flag)
        else $error("summation request not set");
    conv_set_a: assert property (conv_done // RL9
        |=> conv_result_hold)
        else $error("conversion hold not raised");
    conv_clear_a: assert property (conv_result_hold && conv_lsb_read && !conv_done // RL9
        |=> !conv_result_hold)
        else $error("conversion request not cleared");
    aux_open_a: assert property (extended_irq_control[`AIB_BIT_EXT_AUX] // RL10
        && aux_irq_status != 8'h00 |-> aux_irq)
        else $error("auxiliary request blocked by open gate");
    aux_free_a: assert property (!interrupt_enable[`AIB_BIT_GLOBAL] // RL11
        && extended_irq_control[`AIB_BIT_EXT_AUX] && aux_irq_status != 8'h00 |-> aux_irq)
        else $error("global gate blocked auxiliary request");
    classic_mask_a: assert property ((classic_irq & ~interrupt_enable[6:0]) == 7'h00 // RL12
        && (classic_irq & ~classic_req) == 7'h00)
        else $error("classic request passed its mask");
    classic_pass_a: assert property (interrupt_enable[`AIB_BIT_GLOBAL] // RL11
        && (classic_req & interrupt_enable[6:0]) != 7'h00 |-> classic_irq != 7'h00)
        else $error("enabled classic request blocked");
    ie_write_a: assert property (sfr_req.wr && hit_ie // RL12
        |=> interrupt_enable == $past(sfr_req.wdata))
        else $error("interrupt enable not stored");
    bp_low_a: assert property (sfr_req.wr && hit_bpl // RL17
        |=> breakpoint_addr_low == $past(sfr_req.wdata))
        else $error("breakpoint low byte not stored");
    bp_high_a: assert property (sfr_req.wr && hit_bph // RL17
        |=> breakpoint_addr_high == $past(sfr_req.wdata))
        else $error("breakpoint high byte not stored");
    bp_cfg_en_a: assert property (wr_breakpoint_control // RL16
        |=> bp_en[$past(memory_control_select)] == $past(sfr_req.wdata[`AIB_BIT_BP_EN]))
        else $error("breakpoint enable not armed");
    bp_cfg_space_a: assert property (wr_breakpoint_control // RL15
        |=> bp_space[$past(memory_control_select)] == $past(sfr_req.wdata[`AIB_BIT_BP_SPACE]))
        else $error("breakpoint space not armed");
    bp_clear_a: assert property (wr_breakpoint_control && sfr_req.wdata[`AIB_BIT_BP_STAT] // RL14
        && !bp_hit[memory_control_select] |=> !bp_match[$past(memory_control_select)])
        else $error("breakpoint match not cleared");
    bp_keep_a: assert property (wr_breakpoint_control && !sfr_req.wdata[`AIB_BIT_BP_STAT] // RL14
        && bp_match[memory_control_select] |=> bp_match[$past(memory_control_select)])
        else $error("breakpoint match cleared by zero");
    bp_data_only_a: assert property (bp_en[0] && !bp_space[0] && !data_access.valid // RL15
        && !bp_match[0] |=> !bp_match[0])
        else $error("data breakpoint matched a fetch");
    bp_data_hit_a: assert property (bp_en[0] && !bp_space[0] && data_access.valid // RL17
        && data_access.addr == bp_addr[0] |=> bp_match[0])
        else $error("data breakpoint missed");
    bp_prog_hit_a: assert property (bp_en[NUM_BP-1] && bp_space[NUM_BP-1] // RL15
        && prog_fetch.valid && prog_fetch.addr == bp_addr[NUM_BP-1] |=> bp_match[NUM_BP-1])
        else $error("program breakpoint missed");
    bp_off_a: assert property (!bp_en[NUM_BP-1] && !bp_match[NUM_BP-1] // RL16
        |=> !bp_match[NUM_BP-1])
        else $error("disabled breakpoint matched");
    reset_clear_a: assert property ($past(rst) // RL21
        |-> aux_mask == 8'h00 && interrupt_enable == 8'h00 && view_sel == 1'b0
        && sfr_rdata == 8'h00 && bp_match == '0 && !summation_irq_flag && !conv_result_hold)
        else $error("register not cleared by reset");

    cov_bp_hit_c: cover property (wr_breakpoint_control ##[1:20] |bp_hit);
    cov_aux_irq_c: cover property (aux_irq && aux_pending_index == 4'h6);
    cov_classic_c: cover property (|classic_irq);
    cov_view_c: cover property (sfr_req.rd && hit_en && view_sel);
    cov_set_wins_c: cover property (conv_done && conv_lsb_read && conv_result_hold);
endmodule // aib_irq_break_ctrl

// [aib_core_model.sv]
// Processor core model issuing register bus cycles
module aib_core_model (
    input wire logic clk,
    output aib_pkg::aib_sfr_req_t sfr_req,
    input wire logic [7:0] sfr_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    import aib_pkg::*;
    initial sfr_req = '0;
    // Strobes last one cycle; a gap cycle keeps two calls off the same edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        sfr_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge clk);
        sfr_req.wr <= 1'b0;
        // Let the written register settle before the caller looks at outputs
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        sfr_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clk);
        sfr_req.rd <= 1'b0;
        #1;
        d = sfr_rdata;
    endtask
endmodule // aib_core_model

// [aib_irq_break_ctrl_test.sv]
// Self-checking bench for the interrupt and breakpoint block
module aib_irq_break_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    import aib_pkg::*;
    logic clk, rst, sum_done, sum_lsb_read, conv_done, conv_lsb_read;
    logic conv_result_hold, aux_irq;
    logic [7:0] sfr_rdata, extended_irq_control;
    logic [15:0] aux_vector_addr;
    logic [6:0] classic_req, classic_irq;
    logic [0:0] memory_control_select;
    aib_sfr_req_t sfr_req;
    aib_aux_level_t aux_level;
    aib_mem_access_t data_access, prog_fetch;
    int errors = 0;
    int tests_run = 0;
    aib_core_model u_core (.clk(clk), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata));
    aib_irq_break_ctrl u_dut (.clk(clk), .rst(rst), .sfr_req(sfr_req),
        .sfr_rdata(sfr_rdata), .aux_level(aux_level), .sum_done(sum_done),
        .sum_lsb_read(sum_lsb_read), .conv_done(conv_done),
        .conv_lsb_read(conv_lsb_read), .conv_result_hold(conv_result_hold),
        .extended_irq_control(extended_irq_control), .aux_irq(aux_irq),
        .aux_vector_addr(aux_vector_addr), .classic_req(classic_req),
        .classic_irq(classic_irq), .memory_control_select(memory_control_select),
        .data_access(data_access), .prog_fetch(prog_fetch));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic final_report();
        if (errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        u_core.rd(a, v);
        chk(16'(v), 16'(exp));
    endtask
    // Bits: sum_done, conv_done, sum_lsb_read, conv_lsb_read
    task automatic pls(input logic [3:0] m);
        @(posedge clk);
        {sum_done, conv_done, sum_lsb_read, conv_lsb_read} <= m;
        @(posedge clk);
        {sum_done, conv_done, sum_lsb_read, conv_lsb_read} <= 4'h0;
        #1;
    endtask
    task automatic acc(input logic d, input logic p, input logic [15:0] a);
        @(posedge clk);
        data_access <= '{addr: a, valid: d};
        prog_fetch <= '{addr: a, valid: p};
        @(posedge clk);
        data_access.valid <= 1'b0;
        prog_fetch.valid <= 1'b0;
    endtask
    task automatic t_reset();
        for (int i = 0; i < 9; i++)
            rchk((i == 8) ? 8'hA0 : 8'(8'hA4 + i), 8'h00);
    endtask
    task automatic t_aux();
        @(posedge clk);
        aux_level <= '1;
        pls(4'hC);
        for (int i = 0; i < 8; i++)
        begin
            u_core.wr(8'hA6, 8'(8'hFF << i));
            rchk(8'hA7, 8'(8'hFF << i));
            rchk(8'hA5, 8'(i + 1));
        end
        u_core.wr(8'hA6, 8'h00);
        rchk(8'hA5, 8'h00);
        rchk(8'hA6, 8'hFF);
        rchk(8'hA4, 8'h00);
        u_core.wr(8'hA4, 8'h01);
        rchk(8'hA6, 8'h00);
        rchk(8'hA4, 8'hFF);
        u_core.wr(8'hA4, 8'h00);
    endtask
    task automatic t_flags();
        u_core.wr(8'hA6, 8'h60);
        chk(16'(conv_result_hold), 16'h0001);
        pls(4'h5);
        rchk(8'hA7, 8'h60);
        pls(4'h1);
        chk(16'(conv_result_hold), 16'h0000);
        pls(4'h2);
        rchk(8'hA7, 8'h00);
    endtask
    task automatic t_gates();
        u_core.wr(8'hA6, 8'h01);
        u_core.wr(8'hA5, 8'hFF);
        rchk(8'hA5, 8'h01);
        chk(16'(aux_irq), 16'h0000);
        @(posedge clk);
        extended_irq_control <= 8'h10;
        classic_req <= 7'h7F;
        u_core.wr(8'hA8, 8'h7F);
        chk(16'(aux_irq), 16'h0001);
        chk(aux_vector_addr, 16'h0033);
        chk(16'(classic_irq), 16'h0000);
        u_core.wr(8'hA8, 8'hA5);
        chk(16'(classic_irq), 16'h0025);
        rchk(8'hA8, 8'hA5);
    endtask
    task automatic t_break();
        @(posedge clk);
        aux_level <= '0;
        u_core.wr(8'hAA, 8'h34);
        u_core.wr(8'hAB, 8'h12);
        u_core.wr(8'hA9, 8'h01);
        acc(1'b0, 1'b1, 16'h1234);
        rchk(8'hA7, 8'h00);
        acc(1'b1, 1'b0, 16'h1235);
        rchk(8'hA9, 8'h01);
        acc(1'b1, 1'b0, 16'h1234);
        rchk(8'hA9, 8'h81);
        rchk(8'hA7, 8'h01);
        u_core.wr(8'hA9, 8'h81);
        rchk(8'hA9, 8'h01);
        @(posedge clk);
        memory_control_select <= 1'b1;
        u_core.wr(8'hAB, 8'h56);
        u_core.wr(8'hA9, 8'h03);
        acc(1'b1, 1'b0, 16'h5634);
        rchk(8'hA9, 8'h03);
        acc(1'b0, 1'b1, 16'h5634);
        rchk(8'hA9, 8'h83);
        u_core.wr(8'hA9, 8'h02);
        rchk(8'hA9, 8'h82);
        u_core.wr(8'hA9, 8'h82);
        acc(1'b0, 1'b1, 16'h5634);
        rchk(8'hA9, 8'h02);
    endtask
    initial
    begin
        rst = 1'b1;
        {sum_done, conv_done, sum_lsb_read, conv_lsb_read} = 4'h0;
        aux_level = '0;
        extended_irq_control = 8'h00;
        classic_req = 7'h00;
        memory_control_select = 1'b0;
        data_access = '0;
        prog_fetch = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_aux();
        t_flags();
        t_gates();
        t_break();
        final_report();
    end
    // Whole run needs well under 400 cycles
    initial
    begin
        #50000;
        errors++;
        final_report();
    end
endmodule // aib_irq_break_ctrl_test
